// file: rtl/rsw_status.sv
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module rsw_status #(
    parameter int ADDR_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rsw_pkg::rsw_role_t local_role_req,
    input wire logic exch_valid,
    input wire rsw_pkg::rsw_role_t exch_partner_role,
    input wire logic exch_logic_differs,
    input wire logic copro_start_valid,
    input wire logic copro_order_b,
    input wire logic copro_ok,
    output rsw_pkg::rsw_role_t local_role
);
    import rsw_pkg::*;

    // ****************************************
    // parameters and register indices
    // ****************************************
    // decode looks at word index bits only, byte offset bits ignored
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_addr_w_bad
        $error("ADDR_W outside the range the register map can decode");
    end

    localparam int IDX_W = ADDR_W - 2;
    localparam logic [IDX_W-1:0] IDX_STATUS = IDX_W'(`RSW_OFF_STATUS >> 2);
    localparam logic [IDX_W-1:0] IDX_COMMAND = IDX_W'(`RSW_OFF_COMMAND >> 2);
    localparam logic [IDX_W-1:0] IDX_PARTNER = IDX_W'(`RSW_OFF_PARTNER >> 2);

    typedef struct packed {
        rsw_bus_t wst;
        rsw_bus_t rst;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] command;
        rsw_role_t partner_role;
        logic differs;
        logic order_b;
        logic order_seen;
        logic active;
        rsw_role_t role;
    } rsw_state_t;

    rsw_state_t state;
    rsw_state_t next_state;
    logic [1:0] ok_sync;
    logic [15:0] status_word;

    // ****************************************
    // input synchroniser
    // ****************************************
    // coprocessor health is a level from another domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ok_sync <= 2'h0;
        end else begin
            ok_sync <= {ok_sync[0], copro_ok};
        end
    end

    // ****************************************
    // status word assembly
    // ****************************************
    always_comb begin
        status_word = 16'h0000;
        status_word[`RSW_BIT_LOCAL_ROLE +: 2] = state.role;
        status_word[`RSW_BIT_REMOTE_ROLE +: 2] = state.partner_role;
        status_word[`RSW_BIT_MISMATCH] = state.differs & state.command[`RSW_BIT_TOLERANCE];
        status_word[`RSW_BIT_ORDER] = state.order_b;
        status_word[`RSW_BIT_BLOCKED] = state.differs;
        status_word[`RSW_BIT_ACTIVE] = state.active;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_state = state;
        if (exch_valid) begin
            next_state.partner_role = exch_partner_role;
            next_state.differs = exch_logic_differs;
        end
        if (copro_start_valid && !state.order_seen) begin
            next_state.order_b = copro_order_b;
            next_state.order_seen = 1'b1;
        end
        next_state.active = ok_sync[1];
        // standby request forced offline on mismatch while tolerance bit is clear
        // role rebuilt every cycle, so standby returns once mismatch clears
        if (local_role_req == `RSW_ROLE_STANDBY && next_state.differs
            && !state.command[`RSW_BIT_TOLERANCE]) begin
            next_state.role = `RSW_ROLE_OFFLINE;
        end else if (local_role_req == 2'h0) begin
            next_state.role = `RSW_ROLE_OFFLINE;
        end else begin
            next_state.role = local_role_req;
        end

        // write channel
        next_state.awready = 1'b0;
        next_state.wready = 1'b0;
        case (state.wst)
            RSW_BUS_IDLE: begin
                if (s_axi_awvalid && !state.aw_got) begin
                    next_state.aw_got = 1'b1;
                    next_state.awaddr = s_axi_awaddr;
                    next_state.awready = 1'b1;
                end
                if (s_axi_wvalid && !state.w_got) begin
                    next_state.w_got = 1'b1;
                    next_state.wdata = s_axi_wdata;
                    next_state.wstrb = s_axi_wstrb;
                    next_state.wready = 1'b1;
                end
                if (state.aw_got && state.w_got) begin
                    next_state.aw_got = 1'b0;
                    next_state.w_got = 1'b0;
                    next_state.bvalid = 1'b1;
                    next_state.wst = RSW_BUS_WRESP;
                    case (state.awaddr[ADDR_W-1:2])
                        IDX_COMMAND: begin
                            next_state.bresp = `RSW_RESP_OKAY;
                            // word is 16 bits, upper lanes have nothing to land in
                            if (state.wstrb[0]) begin
                                next_state.command[7:0] = state.wdata[7:0];
                            end
                            if (state.wstrb[1]) begin
                                next_state.command[15:8] = state.wdata[15:8];
                            end
                        end
                        IDX_STATUS, IDX_PARTNER: begin
                            next_state.bresp = `RSW_RESP_OKAY;
                        end
                        default: begin
                            next_state.bresp = `RSW_RESP_SLVERR;
                        end
                    endcase
                end
            end
            RSW_BUS_WRESP: begin
                if (s_axi_bready) begin
                    next_state.bvalid = 1'b0;
                    next_state.wst = RSW_BUS_IDLE;
                end
            end
            default: begin
                next_state.wst = RSW_BUS_IDLE;
            end
        endcase

        // read channel
        next_state.arready = 1'b0;
        case (state.rst)
            RSW_BUS_IDLE: begin
                if (s_axi_arvalid) begin
                    next_state.arready = 1'b1;
                    next_state.rvalid = 1'b1;
                    next_state.rresp = `RSW_RESP_OKAY;
                    next_state.rst = RSW_BUS_RDATA;
                    case (s_axi_araddr[ADDR_W-1:2])
                        IDX_STATUS: begin
                            next_state.rdata = {16'h0000, status_word};
                        end
                        IDX_COMMAND: begin
                            next_state.rdata = {16'h0000, state.command};
                        end
                        IDX_PARTNER: begin
                            next_state.rdata = {30'h0000_0000, state.partner_role};
                        end
                        default: begin
                            // unmapped reads return zero so no stale data leaks
                            next_state.rdata = 32'h0000_0000;
                            next_state.rresp = `RSW_RESP_SLVERR;
                        end
                    endcase
                end
            end
            RSW_BUS_RDATA: begin
                if (s_axi_rready) begin
                    next_state.rvalid = 1'b0;
                    next_state.rst = RSW_BUS_IDLE;
                end
            end
            default: begin
                next_state.rst = RSW_BUS_IDLE;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.wst <= RSW_BUS_IDLE;
            state.rst <= RSW_BUS_IDLE;
            state.command <= `RSW_RST_COMMAND;
            state.role <= `RSW_ROLE_OFFLINE;
            state.partner_role <= `RSW_ROLE_OFFLINE;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rresp = state.rresp;
    assign s_axi_rdata = state.rdata;
    assign local_role = state.role;
endmodule : rsw_status

// file: pkg/rsw_cfg.svh
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH
`define RSW_OFF_STATUS 32'h0000_0000
`define RSW_OFF_COMMAND 32'h0000_0004
`define RSW_OFF_PARTNER 32'h0000_0008
`define RSW_BIT_LOCAL_ROLE 0
`define RSW_BIT_REMOTE_ROLE 2
`define RSW_BIT_MISMATCH 4
`define RSW_BIT_ORDER 5
`define RSW_BIT_BLOCKED 14
`define RSW_BIT_ACTIVE 15
`define RSW_BIT_TOLERANCE 3
`define RSW_ROLE_OFFLINE 2'h1
`define RSW_ROLE_PRIMARY 2'h2
`define RSW_ROLE_STANDBY 2'h3
`define RSW_RST_COMMAND 16'h0000
`define RSW_RESP_OKAY 2'h0
`define RSW_RESP_SLVERR 2'h2
`endif

// file: pkg/rsw_pkg.sv
package rsw_pkg;
    typedef enum logic [2:0] {
        RSW_BUS_IDLE = 3'h1,
        RSW_BUS_WRESP = 3'h2,
        RSW_BUS_RDATA = 3'h4
    } rsw_bus_t;
    typedef logic [1:0] rsw_role_t;
endpackage : rsw_pkg

// file: testbench/rsw_checker.sv
`timescale 1ns/1ps
// ****
// status block checks
// ****
module rsw_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rsw_pkg::rsw_role_t local_role_req,
    input wire rsw_pkg::rsw_role_t local_role
);
    import rsw_pkg::*;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // read idle and a new address offered
    sequence rd_idle_req;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    endsequence
    sequence rd_answer;
        s_axi_arready && s_axi_rvalid;
    endsequence
    // read data offered and not yet taken
    sequence rd_stall;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    sequence rd_held;
        s_axi_rvalid && $stable(s_axi_rdata);
    endsequence
    sequence role_plain;
        local_role_req inside {2'h1, 2'h2};
    endsequence
    read_answer_a: assert property (rd_idle_req |=> rd_answer)
        else $error("read answer late");
    read_hold_a: assert property (rd_stall |=> rd_held)
        else $error("read data dropped");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper bits set");
    write_resp_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready stuck");
    role_follow_a: assert property (role_plain |=> local_role == $past(local_role_req))
        else $error("role not followed");
    role_zero_a: assert property (local_role_req == 2'h0 |=> local_role == 2'h1)
        else $error("empty role not offline");
    role_coded_a: assert property (local_role != 2'h0)
        else $error("role code empty");
endmodule : rsw_checker

bind rsw_status rsw_checker i_rsw_checker (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .local_role_req, .local_role);

// file: testbench/rsw_partner.sv
`timescale 1ns/1ps
// ****
// partner controller exchange
// ****
module rsw_partner (
    input wire logic aclk,
    input wire logic send,
    input wire rsw_pkg::rsw_role_t role,
    input wire logic differs,
    output logic exch_valid = 1'b0,
    output rsw_pkg::rsw_role_t exch_partner_role = 2'h0,
    output logic exch_logic_differs = 1'b0
);
    import rsw_pkg::*;
    // one exchange a pulse
    // lines not held between exchanges, so stale values are inverted
    always_ff @(posedge aclk) begin
        exch_valid <= send;
        exch_partner_role <= send ? role : ~exch_partner_role;
        exch_logic_differs <= send ? differs : ~exch_logic_differs;
    end
endmodule : rsw_partner

// file: testbench/testbench.sv
`timescale 1ns/1ps
`include "rsw_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
// ****
// status word bench
// ****
module testbench;
    import rsw_pkg::*;
    localparam logic [3:0] ST = 4'(`RSW_OFF_STATUS);
    localparam logic [3:0] CM = 4'(`RSW_OFF_COMMAND);
    localparam logic [3:0] PR = 4'(`RSW_OFF_PARTNER);
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, exch_valid, exch_logic_differs, copro_ok = 0;
    logic copro_start_valid = 0, copro_order_b = 0, send = 0, p_diff = 0, ord = 0, act = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    rsw_role_t local_role_req = 2'h1, exch_partner_role, local_role, p_role = 2'h1;
    int bad_count = 0, n_tests = 0, cyc = 0;
    logic slow = 0;
    rsw_status i_rsw_status (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .local_role_req, .exch_valid,
        .exch_partner_role, .exch_logic_differs, .copro_start_valid, .copro_order_b,
        .copro_ok, .local_role);
    rsw_partner i_rsw_partner (.aclk, .send, .role(p_role), .differs(p_diff), .exch_valid,
        .exch_partner_role, .exch_logic_differs);
    initial forever #12.5 aclk = ~aclk;
    // runs take a few hundred cycles, ceiling leaves margin
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    function automatic logic [31:0] sw(input logic [1:0] lr, pr, input logic d, t);
        return {16'h0000, act, d, 8'h00, ord, d & t, pr, lr};
    endfunction : sw
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= !slow;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1;
        end while (!(s_axi_bvalid && s_axi_bready));
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= !slow;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
        end while (!(s_axi_rvalid && s_axi_rready));
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask : rd
    task automatic check_sw(input logic [31:0] e);
        rd(ST);
        `CHK(rd_d, e)
    endtask : check_sw
    task automatic exch(input rsw_role_t r, input logic d);
        @(posedge aclk);
        p_role <= r;
        p_diff <= d;
        send <= 1;
        @(posedge aclk);
        send <= 0;
        repeat (2) @(posedge aclk);
    endtask : exch
    task automatic t_reset;
        check_sw(sw(2'h1, 2'h1, 0, 0));
        rd(CM);
        `CHK(rd_d, 32'h0)
        $display("reset test done");
    endtask : t_reset
    task automatic t_roles;
        for (int l = 0; l < 4; l++) begin
            for (int p = 1; p < 4; p++) begin
                local_role_req <= 2'(l);
                exch(2'(p), 0);
                check_sw(sw((l == 0) ? 2'h1 : 2'(l), 2'(p), 0, 0));
            end
        end
        $display("role test done");
    endtask : t_roles
    task automatic t_mismatch;
        wr(CM, 32'h8);
        exch(2'h2, 1);
        check_sw(sw(2'h3, 2'h2, 1, 1));
        wr(CM, 32'h0);
        check_sw(sw(2'h1, 2'h2, 1, 0));
        `CHK(local_role, 2'h1)
        exch(2'h2, 0);
        check_sw(sw(2'h3, 2'h2, 0, 0));
        $display("mismatch test done");
    endtask : t_mismatch
    task automatic t_copro;
        copro_order_b <= 1;
        copro_start_valid <= 1;
        @(posedge aclk);
        copro_order_b <= 0;
        copro_ok <= 1;
        @(posedge aclk);
        copro_start_valid <= 0;
        ord = 1;
        act = 1;
        repeat (4) @(posedge aclk);
        check_sw(sw(2'h3, 2'h2, 0, 0));
        $display("copro test done");
    endtask : t_copro
    task automatic t_ro;
        // readies held back so the stall paths get walked
        slow = 1;
        wr(ST, 32'hffff_ffff);
        `CHK(rsp, `RSW_RESP_OKAY)
        check_sw(sw(2'h3, 2'h2, 0, 0));
        slow = 0;
        wr(PR, 32'h3);
        `CHK(rsp, `RSW_RESP_OKAY)
        rd(PR);
        `CHK(rd_d, 32'h2)
        s_axi_wstrb <= 4'h2;
        wr(CM, 32'hffff_ff08);
        `CHK(rsp, `RSW_RESP_OKAY)
        s_axi_wstrb <= 4'hf;
        rd(CM);
        `CHK(rd_d, 32'h0000_ff00)
        wr(4'hc, 32'h1);
        `CHK(rsp, `RSW_RESP_SLVERR)
        rd(4'hc);
        `CHK(rsp, `RSW_RESP_SLVERR)
        $display("read-only test done");
    endtask : t_ro
    task automatic t_rst;
        @(posedge aclk);
        aresetn <= 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        // order and command clear, health needs three edges to return
        ord = 0;
        act = 0;
        check_sw(sw(2'h3, 2'h1, 0, 0));
        act = 1;
        check_sw(sw(2'h3, 2'h1, 0, 0));
        rd(CM);
        `CHK(rd_d, 32'h0)
        $display("second reset test done");
    endtask : t_rst
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_reset();
        t_roles();
        t_mismatch();
        t_copro();
        t_ro();
        t_rst();
        finish_test();
    end
endmodule : testbench
